// >>> shared/vic_pkg.sv
// Constants shared by the vectored interrupt controller.
package vic_pkg;
  localparam int NUM_MASKABLE = 19;
  localparam int NUM_EDGE = 6;
  localparam int SRC_W = 5;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  // Register addresses.
  localparam logic [15:0] ADDR_REQUEST_FLAGS_0 = 16'hFFE0;
  localparam logic [15:0] ADDR_REQUEST_FLAGS_1 = 16'hFFE1;
  localparam logic [15:0] ADDR_REQUEST_FLAGS_2 = 16'hFFE2;
  localparam logic [15:0] ADDR_MASK_FLAGS_0 = 16'hFFE4;
  localparam logic [15:0] ADDR_MASK_FLAGS_1 = 16'hFFE5;
  localparam logic [15:0] ADDR_MASK_FLAGS_2 = 16'hFFE6;
  localparam logic [15:0] ADDR_PRIORITY_FLAGS_LOW_GROUP0 = 16'hFFE8;
  localparam logic [15:0] ADDR_PRIORITY_FLAGS_HIGH_GROUP0 = 16'hFFE9;
  localparam logic [15:0] ADDR_PRIORITY_FLAGS_GROUP1 = 16'hFFEA;
  localparam logic [15:0] ADDR_EDGE_RISE = 16'hFFF0;
  localparam logic [15:0] ADDR_EDGE_FALL = 16'hFFF1;
  localparam logic [15:0] ADDR_CONTROL = 16'hFFF2;
  localparam logic [15:0] ADDR_STATUS = 16'hFFF3;
  // Reset values.
  localparam logic [7:0] REQUEST_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'hFF;
  localparam logic [7:0] PRIORITY_RESET = 8'hFF;
  localparam logic [7:0] EDGE_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  // Field positions.
  localparam int CTRL_WDT_NMI_BIT = 0;
  localparam int ST_SVC_HIGH_BIT = 0;
  localparam int ST_SVC_LOW_BIT = 1;
  localparam int ST_SVC_NMI_BIT = 2;
  localparam int ST_NMI_PEND_BIT = 3;
  localparam int ST_BREAK_PEND_BIT = 4;
  // Request indices, equal to the default priority.
  localparam int IDX_WDT = 0;
  localparam int IDX_CONV = 1;
  localparam int IDX_WIDE_OVF = 2;
  localparam int IDX_CAPTURE0 = 3;
  localparam int IDX_PIN0 = 6;
  localparam int IDX_SERIAL0 = 9;
  localparam int IDX_BYTE_TIMER1 = 13;
  localparam int IDX_NVM = 16;
  localparam int IDX_WATCH_OVF = 17;
  localparam int IDX_WATCH_INT = 18;
  // Source codes beyond the maskable ones.
  localparam logic [4:0] SRC_NMI = 5'h13;
  localparam logic [4:0] SRC_BREAK = 5'h14;
  // Vector addresses.
  localparam logic [15:0] VEC_NMI = 16'h0004;
  localparam logic [15:0] VEC_BREAK = 16'h003E;
  localparam logic [15:0] VEC_MASK_BASE = 16'h0004;
  localparam int VEC_STEP_SHIFT = 1;
endpackage : vic_pkg

// >>> hw/vic_edge_det.sv
// Pin synchroniser with selectable rising and falling edge detection.
`timescale 1ns/1ps
module vic_edge_det (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Pin and edge selection.
  input wire logic i_pin,
  input wire logic i_rise_en,
  input wire logic i_fall_en,
  // One-cycle edge pulse.
  output logic o_edge
);
  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic edge_q;

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      sync1_q <= i_pin;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      edge_q <= 1'b0;
    end else begin
      edge_q <= (sync2_q & ~prev_q & i_rise_en) | (~sync2_q & prev_q & i_fall_en);
    end
  end

  assign o_edge = edge_q;
endmodule : vic_edge_det

// >>> hw/vic_top.sv
// Vectored interrupt controller: flags, arbitration, nesting and vector output.
// What this block does
// - NMI ignores enable, beats every other request
// - Watchdog NMI option vectors to 0004H
// - Masks gate requests; pending ones release standby
// - Priority flag puts each source high or low
// - High group may preempt low service
// - Equal group ties go to lowest number
// - Six pin plus thirteen internal maskable sources
// - Break vectors 003EH, ignores enable and priority
// - Twenty-one sources in all
// - Conversion done 0006H, wide overflow 0008H
// - Capture edges vector 000AH, 000CH, 000EH
// - Pin edges vector 0010H, 0012H, 0014H
// - Serial events vector 0016H through 001CH
// - Byte timer matches vector 001EH to 0022H
// - NVM 0024H, watch 0026H, interval 0028H
// - Flags set by event or write, cleared by acknowledge
// - Masks reset to all ones
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module vic_top (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Register port.
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Processor core.
  input wire logic i_int_enable,
  input wire logic i_core_ack,
  input wire logic i_core_return,
  input wire logic i_software_break_instruction,
  output logic o_int_req,
  output logic [15:0] o_vector,
  output logic [4:0] o_source,
  output logic o_nonmaskable,
  output logic o_standby_release,
  // Internal event pulses.
  input wire logic i_watchdog_overflow_request,
  input wire logic i_conversion_done_request,
  input wire logic i_wide_timer_overflow_request,
  input wire logic i_clocked_serial_done_request,
  input wire logic i_async_rx_error_request,
  input wire logic i_async_rx_done_request,
  input wire logic i_async_tx_done_request,
  input wire logic i_byte_timer1_match_request,
  input wire logic i_byte_timer2_match_request,
  input wire logic i_byte_timer3_match_request,
  input wire logic i_nvm_write_done_request,
  input wire logic i_watch_overflow_request,
  input wire logic i_watch_interval_request,
  // Pins.
  input wire logic [2:0] i_capture_pin,
  input wire logic [2:0] i_ext_pin
);
  localparam int N = vic_pkg::NUM_MASKABLE;

  logic [N-1:0] req_q;
  logic [N-1:0] req_d;
  logic [N-1:0] mask_flag_q;
  logic [N-1:0] priority_flag_q;
  logic [7:0] edge_rise_q;
  logic [7:0] edge_fall_q;
  logic [7:0] control_q;
  logic nmi_pend_q;
  logic break_pend_q;
  logic svc_high_q;
  logic svc_low_q;
  logic svc_nmi_q;
  logic int_req_q;
  logic [15:0] vector_q;
  logic [4:0] source_q;
  logic nonmaskable_q;
  logic standby_q;
  logic [7:0] rdata_q;
  logic [N-1:0] grp_el_q;

  logic [5:0] edge_pulse;
  logic [5:0] edge_pins;
  logic [N-1:0] ev;
  logic [N-1:0] eligible;
  logic [N-1:0] high_el;
  logic [N-1:0] low_el;
  logic [N-1:0] grp_el;
  logic wdt_nmi_sel;
  logic ack_hit;
  logic ack_mask;
  logic cand_valid;
  logic [4:0] cand_src;
  logic [15:0] cand_vec;
  logic [7:0] status;

  assign wdt_nmi_sel = control_q[vic_pkg::CTRL_WDT_NMI_BIT];
  assign ack_hit = i_core_ack & int_req_q;
  assign ack_mask = ack_hit & (source_q < vic_pkg::SRC_NMI);
  assign edge_pins = {i_ext_pin, i_capture_pin};

  // Capture inputs then external pins, each synchronised and edge detected.
  genvar g;
  generate
    for (g = 0; g < vic_pkg::NUM_EDGE; g++) begin : g_edge
      vic_edge_det u_edge (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_pin(edge_pins[g]),
        .i_rise_en(edge_rise_q[g]),
        .i_fall_en(edge_fall_q[g]),
        .o_edge(edge_pulse[g])
      );
    end
  endgenerate

  // Index equals default priority number.
  always_comb begin
    ev = '0;
    ev[vic_pkg::IDX_WDT] = i_watchdog_overflow_request & ~wdt_nmi_sel;
    ev[vic_pkg::IDX_CONV] = i_conversion_done_request;
    ev[vic_pkg::IDX_WIDE_OVF] = i_wide_timer_overflow_request;
    ev[vic_pkg::IDX_CAPTURE0 +: 3] = edge_pulse[2:0];
    ev[vic_pkg::IDX_PIN0 +: 3] = edge_pulse[5:3];
    ev[vic_pkg::IDX_SERIAL0 + 0] = i_clocked_serial_done_request;
    ev[vic_pkg::IDX_SERIAL0 + 1] = i_async_rx_error_request;
    ev[vic_pkg::IDX_SERIAL0 + 2] = i_async_rx_done_request;
    ev[vic_pkg::IDX_SERIAL0 + 3] = i_async_tx_done_request;
    ev[vic_pkg::IDX_BYTE_TIMER1 + 0] = i_byte_timer1_match_request;
    ev[vic_pkg::IDX_BYTE_TIMER1 + 1] = i_byte_timer2_match_request;
    ev[vic_pkg::IDX_BYTE_TIMER1 + 2] = i_byte_timer3_match_request;
    ev[vic_pkg::IDX_NVM] = i_nvm_write_done_request;
    ev[vic_pkg::IDX_WATCH_OVF] = i_watch_overflow_request;
    ev[vic_pkg::IDX_WATCH_INT] = i_watch_interval_request;
  end

  // An event in the cycle of a write or acknowledge still sets its flag.
  always_comb begin
    req_d = req_q;
    if (i_wr && i_addr == vic_pkg::ADDR_REQUEST_FLAGS_0) begin
      req_d[7:0] = i_wdata;
    end
    if (i_wr && i_addr == vic_pkg::ADDR_REQUEST_FLAGS_1) begin
      req_d[15:8] = i_wdata;
    end
    if (i_wr && i_addr == vic_pkg::ADDR_REQUEST_FLAGS_2) begin
      req_d[18:16] = i_wdata[2:0];
    end
    if (ack_mask) begin
      req_d[source_q] = 1'b0;
    end
    req_d = req_d | ev;
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      req_q <= {vic_pkg::REQUEST_RESET[2:0], vic_pkg::REQUEST_RESET, vic_pkg::REQUEST_RESET};
    end else begin
      req_q <= req_d;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mask_flag_q <= {vic_pkg::MASK_RESET[2:0], vic_pkg::MASK_RESET, vic_pkg::MASK_RESET};
      priority_flag_q <= {vic_pkg::PRIORITY_RESET[2:0], vic_pkg::PRIORITY_RESET,
                          vic_pkg::PRIORITY_RESET};
    end else if (i_wr) begin
      unique case (i_addr)
        vic_pkg::ADDR_MASK_FLAGS_0: mask_flag_q[7:0] <= i_wdata;
        vic_pkg::ADDR_MASK_FLAGS_1: mask_flag_q[15:8] <= i_wdata;
        vic_pkg::ADDR_MASK_FLAGS_2: mask_flag_q[18:16] <= i_wdata[2:0];
        vic_pkg::ADDR_PRIORITY_FLAGS_LOW_GROUP0: priority_flag_q[7:0] <= i_wdata;
        vic_pkg::ADDR_PRIORITY_FLAGS_HIGH_GROUP0: priority_flag_q[15:8] <= i_wdata;
        vic_pkg::ADDR_PRIORITY_FLAGS_GROUP1: priority_flag_q[18:16] <= i_wdata[2:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      edge_rise_q <= vic_pkg::EDGE_RESET;
      edge_fall_q <= vic_pkg::EDGE_RESET;
      control_q <= vic_pkg::CONTROL_RESET;
    end else if (i_wr) begin
      if (i_addr == vic_pkg::ADDR_EDGE_RISE) begin
        edge_rise_q <= {2'h0, i_wdata[5:0]};
      end
      if (i_addr == vic_pkg::ADDR_EDGE_FALL) begin
        edge_fall_q <= {2'h0, i_wdata[5:0]};
      end
      if (i_addr == vic_pkg::ADDR_CONTROL) begin
        control_q <= {7'h00, i_wdata[vic_pkg::CTRL_WDT_NMI_BIT]};
      end
    end
  end

  // Non-maskable and break requests; a new event beats the acknowledge.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      nmi_pend_q <= 1'b0;
      break_pend_q <= 1'b0;
    end else begin
      nmi_pend_q <= (nmi_pend_q & ~(ack_hit & source_q == vic_pkg::SRC_NMI))
                    | (i_watchdog_overflow_request & wdt_nmi_sel);
      break_pend_q <= (break_pend_q & ~(ack_hit & source_q == vic_pkg::SRC_BREAK))
                      | i_software_break_instruction;
    end
  end

  // Service levels, released innermost first on return.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      svc_high_q <= 1'b0;
      svc_low_q <= 1'b0;
      svc_nmi_q <= 1'b0;
    end else if (ack_hit) begin
      if (source_q == vic_pkg::SRC_NMI) begin
        svc_nmi_q <= 1'b1;
      end else if (source_q < vic_pkg::SRC_NMI) begin
        if (priority_flag_q[source_q]) begin
          svc_low_q <= 1'b1;
        end else begin
          svc_high_q <= 1'b1;
        end
      end
    end else if (i_core_return) begin
      if (svc_nmi_q) begin
        svc_nmi_q <= 1'b0;
      end else if (svc_high_q) begin
        svc_high_q <= 1'b0;
      end else begin
        svc_low_q <= 1'b0;
      end
    end
  end

  // Arbitration: NMI, then break, then high group, then low group.
  always_comb begin
    eligible = req_q & ~mask_flag_q;
    high_el = eligible & ~priority_flag_q;
    low_el = eligible & priority_flag_q;
    cand_valid = 1'b0;
    cand_src = '0;
    grp_el = '0;
    if (nmi_pend_q && !svc_nmi_q) begin
      cand_valid = 1'b1;
      cand_src = vic_pkg::SRC_NMI;
    end else if (break_pend_q) begin
      cand_valid = 1'b1;
      cand_src = vic_pkg::SRC_BREAK;
    end else if (i_int_enable && !svc_nmi_q && !svc_high_q && |high_el) begin
      cand_valid = 1'b1;
      grp_el = high_el;
    end else if (i_int_enable && !svc_nmi_q && !svc_high_q && !svc_low_q && |low_el) begin
      cand_valid = 1'b1;
      grp_el = low_el;
    end
    for (int i = N - 1; i >= 0; i--) begin
      if (grp_el[i]) begin
        cand_src = 5'(i);
      end
    end
  end

  // Vector from source code; maskable slots are two bytes apart.
  always_comb begin
    if (cand_src == vic_pkg::SRC_NMI) begin
      cand_vec = vic_pkg::VEC_NMI;
    end else if (cand_src == vic_pkg::SRC_BREAK) begin
      cand_vec = vic_pkg::VEC_BREAK;
    end else begin
      cand_vec = vic_pkg::VEC_MASK_BASE + (16'(cand_src) << vic_pkg::VEC_STEP_SHIFT);
    end
  end

  // The request drops for one cycle after an acknowledge.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      int_req_q <= 1'b0;
      source_q <= '0;
      vector_q <= '0;
      nonmaskable_q <= 1'b0;
      grp_el_q <= '0;
    end else begin
      int_req_q <= cand_valid & ~ack_hit;
      source_q <= cand_src;
      vector_q <= cand_vec;
      nonmaskable_q <= cand_valid & (cand_src == vic_pkg::SRC_NMI);
      grp_el_q <= grp_el;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      standby_q <= 1'b0;
    end else begin
      standby_q <= nmi_pend_q | (|eligible);
    end
  end

  always_comb begin
    status = '0;
    status[vic_pkg::ST_SVC_HIGH_BIT] = svc_high_q;
    status[vic_pkg::ST_SVC_LOW_BIT] = svc_low_q;
    status[vic_pkg::ST_SVC_NMI_BIT] = svc_nmi_q;
    status[vic_pkg::ST_NMI_PEND_BIT] = nmi_pend_q;
    status[vic_pkg::ST_BREAK_PEND_BIT] = break_pend_q;
  end

  // Read data stand for one cycle only; unmapped reads return zero.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_q <= '0;
    end else if (!i_rd) begin
      rdata_q <= '0;
    end else begin
      unique case (i_addr)
        vic_pkg::ADDR_REQUEST_FLAGS_0: rdata_q <= req_q[7:0];
        vic_pkg::ADDR_REQUEST_FLAGS_1: rdata_q <= req_q[15:8];
        vic_pkg::ADDR_REQUEST_FLAGS_2: rdata_q <= {5'h00, req_q[18:16]};
        vic_pkg::ADDR_MASK_FLAGS_0: rdata_q <= mask_flag_q[7:0];
        vic_pkg::ADDR_MASK_FLAGS_1: rdata_q <= mask_flag_q[15:8];
        vic_pkg::ADDR_MASK_FLAGS_2: rdata_q <= {5'h1F, mask_flag_q[18:16]};
        vic_pkg::ADDR_PRIORITY_FLAGS_LOW_GROUP0: rdata_q <= priority_flag_q[7:0];
        vic_pkg::ADDR_PRIORITY_FLAGS_HIGH_GROUP0: rdata_q <= priority_flag_q[15:8];
        vic_pkg::ADDR_PRIORITY_FLAGS_GROUP1: rdata_q <= {5'h1F, priority_flag_q[18:16]};
        vic_pkg::ADDR_EDGE_RISE: rdata_q <= edge_rise_q;
        vic_pkg::ADDR_EDGE_FALL: rdata_q <= edge_fall_q;
        vic_pkg::ADDR_CONTROL: rdata_q <= control_q;
        vic_pkg::ADDR_STATUS: rdata_q <= status;
        default: rdata_q <= '0;
      endcase
    end
  end

  assign o_rdata = rdata_q;
  assign o_int_req = int_req_q;
  assign o_vector = vector_q;
  assign o_source = source_q;
  assign o_nonmaskable = nonmaskable_q;
  assign o_standby_release = standby_q;

  a_nmi_wins_all: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    (nmi_pend_q && !svc_nmi_q) |=> (o_source == vic_pkg::SRC_NMI && o_nonmaskable))
    else $error("pending NMI was not the presented source");

  a_nmi_vector_addr: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    (i_watchdog_overflow_request && wdt_nmi_sel && !svc_nmi_q)
    |=> ##1 (o_vector == vic_pkg::VEC_NMI))
    else $error("watchdog NMI did not vector to its address");

  a_standby_release: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    o_standby_release == $past(nmi_pend_q || (req_q & ~mask_flag_q) != '0))
    else $error("standby release does not follow pending requests");

  a_high_preempts_low: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    (svc_low_q && !svc_high_q && !svc_nmi_q && i_int_enable && high_el != '0 && !ack_hit)
    |=> o_int_req)
    else $error("high group request did not preempt low service");

  a_low_blocked_svc: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    (svc_low_q && high_el == '0 && !nmi_pend_q && !break_pend_q) |=> !o_int_req)
    else $error("low request presented while low service active");

  a_default_order: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    (o_int_req && o_source < vic_pkg::SRC_NMI)
    |-> (grp_el_q & ((19'h00001 << o_source) - 19'h00001)) == '0)
    else $error("a lower numbered request in the group was skipped");

  a_break_taken: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    (i_software_break_instruction && !nmi_pend_q && !i_watchdog_overflow_request)
    |=> ##1 (o_source == vic_pkg::SRC_BREAK && o_vector == vic_pkg::VEC_BREAK))
    else $error("break instruction did not present its vector");

  a_flag_ack_clear: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    (ack_mask && !i_wr && ev == '0) |=> !req_q[$past(source_q)])
    else $error("acknowledged request flag was not cleared");

  a_enable_gates_req: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    (o_int_req && o_source < vic_pkg::SRC_NMI) |-> $past(i_int_enable))
    else $error("maskable request presented while disabled");

  a_vector_spacing: assert property (
    @(posedge i_clock) disable iff (!i_rst_b)
    (o_int_req && o_source < vic_pkg::SRC_NMI)
    |-> o_vector == vic_pkg::VEC_MASK_BASE + 16'(o_source) * 16'h0002)
    else $error("maskable vector does not match its source");
endmodule : vic_top

// >>> verif/vic_core_model.sv
// Processor core model that acknowledges and returns from vectored interrupts.
`timescale 1ns/1ps
module vic_core_model (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Controller side.
  input wire logic i_int_req,
  input wire logic [4:0] i_source,
  input wire logic i_hold,
  output logic o_ack,
  output logic o_return
);
  int wait_cnt;
  int depth;
  int slow;
  // Acknowledge alternates between prompt and slow; a break enters no service level.
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ack <= 1'b0;
      o_return <= 1'b0;
      wait_cnt <= 0;
      depth <= 0;
      slow <= 0;
    end else begin
      o_ack <= 1'b0;
      o_return <= 1'b0;
      if (o_ack) begin
        depth <= depth + ((i_source == 5'h14) ? 0 : 1);
        slow <= 1 - slow;
        wait_cnt <= 0;
      end else if (i_int_req) begin
        if (wait_cnt >= 2 * slow) begin
          o_ack <= 1'b1;
          wait_cnt <= 0;
        end else begin
          wait_cnt <= wait_cnt + 1;
        end
      end else if (depth > 0 && !i_hold) begin
        if (wait_cnt >= 3) begin
          o_return <= 1'b1;
          depth <= depth - 1;
          wait_cnt <= 0;
        end else begin
          wait_cnt <= wait_cnt + 1;
        end
      end
    end
  end
endmodule : vic_core_model

// >>> verif/test_vectored_interrupt_controller.sv
// Self-checking bench for the vectored interrupt controller.
`timescale 1ns/1ps
module test_vectored_interrupt_controller;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic en = 1'b0;
  logic software_break_instruction = 1'b0;
  logic hold = 1'b0;
  logic [18:0] ev = 19'h00000;
  logic [2:0] cap = 3'h0;
  logic [2:0] ext = 3'h0;
  logic [7:0] rdata;
  logic [15:0] vec;
  logic [4:0] src;
  logic irq, nmi, sby, ack, rtn;
  logic [18:0] want, msk, pri;
  logic [5:0] pins;
  int errors = 0;
  int num_checks = 0;
  int seed = 51235;
  int e;
  int q[$];
  localparam logic [15:0] RST_A [13] = '{16'hFFE0, 16'hFFE1, 16'hFFE2, 16'hFFE4, 16'hFFE5,
    16'hFFE6, 16'hFFE8, 16'hFFE9, 16'hFFEA, 16'hFFF0, 16'hFFF1, 16'hFFF2, 16'h1234};
  localparam logic [7:0] RST_D [13] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};

  always #25 clock = ~clock;

  vic_top u_vic_top (
    .i_clock(clock), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_int_enable(en), .i_core_ack(ack),
    .i_core_return(rtn), .i_software_break_instruction(software_break_instruction), .o_int_req(irq),
    .o_vector(vec), .o_source(src), .o_nonmaskable(nmi), .o_standby_release(sby),
    .i_watchdog_overflow_request(ev[0]), .i_conversion_done_request(ev[1]),
    .i_wide_timer_overflow_request(ev[2]), .i_clocked_serial_done_request(ev[9]),
    .i_async_rx_error_request(ev[10]), .i_async_rx_done_request(ev[11]),
    .i_async_tx_done_request(ev[12]), .i_byte_timer1_match_request(ev[13]),
    .i_byte_timer2_match_request(ev[14]), .i_byte_timer3_match_request(ev[15]),
    .i_nvm_write_done_request(ev[16]), .i_watch_overflow_request(ev[17]),
    .i_watch_interval_request(ev[18]), .i_capture_pin(cap), .i_ext_pin(ext)
  );

  vic_core_model u_vic_core_model (
    .i_clock(clock), .i_rst_b(rst_b), .i_int_req(irq), .i_source(src), .i_hold(hold),
    .o_ack(ack), .o_return(rtn)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    check({8'h00, rdata}, {8'h00, exp});
  endtask : rd_chk

  task automatic wr19(input logic [15:0] a, input logic [18:0] v);
    reg_wr(a, v[7:0]);
    reg_wr(a + 16'h0001, v[15:8]);
    reg_wr(a + 16'h0002, {5'h00, v[18:16]});
  endtask : wr19

  task automatic chk19(input logic [15:0] a, input logic [23:0] v);
    rd_chk(a, v[7:0]);
    rd_chk(a + 16'h0001, v[15:8]);
    rd_chk(a + 16'h0002, v[23:16]);
  endtask : chk19

  // Reference order: high group before low group, lower index first inside a group.
  task automatic expect_order(input logic [18:0] live, input logic [18:0] p);
    for (int g = 0; g < 2; g++)
      for (int i = 0; i < 19; i++)
        if (live[i] && p[i] == g[0]) q.push_back(i);
  endtask : expect_order

  task automatic drain();
    for (int k = 0; k < 400 && q.size() > 0; k++) @(posedge clock);
    check(16'(q.size()), 16'h0000);
    repeat (12) @(posedge clock);
  endtask : drain

  task automatic results();
    $display("errors=%0d checks=%0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results

  // Every accepted presentation is compared with the next expected source.
  always @(posedge clock) begin
    if (ack && irq) begin
      e = (q.size() > 0) ? q.pop_front() : 31;
      check(16'(src), 16'(e));
      check(vec, (e == 19) ? 16'h0004 : (e == 20) ? 16'h003E : 16'(4 + 2 * e));
      check(16'(nmi), 16'(e == 19));
    end
  end

  initial begin
    #2000000;
    errors++;
    results();
  end

  initial begin
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    reg_wr(16'h1234, 8'hFF);
    for (int i = 0; i < 13; i++) rd_chk(RST_A[i], RST_D[i]);
    reg_wr(16'hFFE2, 8'hFF);
    rd_chk(16'hFFE2, 8'h07);
    reg_wr(16'hFFE2, 8'h00);
    reg_wr(16'hFFF3, 8'hFF);
    rd_chk(16'hFFF3, 8'h00);
    reg_wr(16'hFFF0, 8'h3F);
    pins = 6'($random(seed)) | 6'h01;
    cap <= pins[2:0];
    ext <= pins[5:3];
    repeat (8) @(posedge clock);
    chk19(16'hFFE0, 24'(pins) << 3);
    wr19(16'hFFE0, 19'h00000);
    cap <= 3'h0;
    ext <= 3'h0;
    repeat (8) @(posedge clock);
    chk19(16'hFFE0, 24'h000000);
    reg_wr(16'hFFF0, 8'h00);
    reg_wr(16'hFFF1, 8'h3F);
    cap <= pins[2:0];
    ext <= pins[5:3];
    repeat (8) @(posedge clock);
    chk19(16'hFFE0, 24'h000000);
    @(posedge clock);
    cap <= 3'h0;
    ext <= 3'h0;
    repeat (8) @(posedge clock);
    chk19(16'hFFE0, 24'(pins) << 3);
    wr19(16'hFFE0, 19'h00000);
    for (int r = 0; r < 8; r++) begin
      want = (r == 0) ? 19'h7FFFF : 19'($random(seed));
      msk = (r == 0) ? 19'h00000 : 19'($random(seed));
      pri = 19'($random(seed));
      wr19(16'hFFE4, msk);
      wr19(16'hFFE8, pri);
      wr19(16'hFFE0, want & 19'h001F8);
      ev <= want & 19'h7FE07;
      @(posedge clock);
      ev <= 19'h00000;
      repeat (3) @(posedge clock);
      check(16'(sby), 16'(|(want & ~msk)));
      check(16'(irq), 16'h0000);
      expect_order(want & ~msk, pri);
      en <= 1'b1;
      drain();
      en <= 1'b0;
      chk19(16'hFFE0, {5'h00, want & msk});
      chk19(16'hFFE4, {5'h1F, msk});
      wr19(16'hFFE0, 19'h00000);
    end
    wr19(16'hFFE4, 19'h00000);
    reg_wr(16'hFFF2, 8'h01);
    q.push_back(19);
    q.push_back(20);
    ev <= 19'h00003;
    software_break_instruction <= 1'b1;
    @(posedge clock);
    ev <= 19'h00000;
    software_break_instruction <= 1'b0;
    drain();
    chk19(16'hFFE0, 24'h000002);
    q.push_back(1);
    @(posedge clock);
    en <= 1'b1;
    drain();
    reg_wr(16'hFFF2, 8'h00);
    wr19(16'hFFE8, 19'h7FF7F);
    hold <= 1'b1;
    q.push_back(5);
    reg_wr(16'hFFE0, 8'h20);
    drain();
    reg_wr(16'hFFE0, 8'h02);
    repeat (6) @(posedge clock);
    check(16'(irq), 16'h0000);
    q.push_back(7);
    reg_wr(16'hFFE0, 8'h82);
    drain();
    rd_chk(16'hFFF3, 8'h03);
    q.push_back(1);
    @(posedge clock);
    hold <= 1'b0;
    drain();
    // A break on its own, with no watchdog event beside it.
    q.push_back(20);
    software_break_instruction <= 1'b1;
    @(posedge clock);
    software_break_instruction <= 1'b0;
    drain();
    results();
  end
endmodule : test_vectored_interrupt_controller
